/* hdl/urx_consts.svh */
`ifndef URX_CONSTS_SVH
`define URX_CONSTS_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define URX_OFS_RX_STATUS_CONTROL 8'h00
`define URX_OFS_RX_DATA 8'h04
`define URX_OFS_BAUD_CONTROL 8'h08
`define URX_OFS_BAUD_DIV_LOW 8'h0c
`define URX_OFS_BAUD_DIV_HIGH 8'h10
`define URX_OFS_TX_STATUS_CONTROL 8'h14
`define URX_OFS_INT_CONTROL 8'h18
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define URX_RSC_PORT_ENABLE 7
`define URX_RSC_NINE_BIT 6
`define URX_RSC_SREN 5
`define URX_RSC_RX_ENABLE 4
`define URX_RSC_ADDR_DETECT 3
`define URX_RSC_FRAMING 2
`define URX_RSC_OVERRUN 1
`define URX_RSC_NINTH 0
`define URX_BC_ABDOVF 7
`define URX_BC_RCIDL 6
`define URX_BC_POL 4
`define URX_BC_WIDE_DIV 3
`define URX_BC_AUTO_BAUD 0
`define URX_TSC_SYNC 4
`define URX_TSC_HIGH_SPEED 2
`define URX_IC_RIE 0
`define URX_IC_FLAG 1
// ----------------------------------------------------------------
// Timing counts and sizes
// ----------------------------------------------------------------
`define URX_OVS_LAST 4'hf
`define URX_OVS_MID 4'h7
`define URX_FIFO_DEPTH 2
`define URX_FIFO_WIDTH 10
`define URX_ABD_MAX 20'hfffff
`endif

/* hdl/urx_pkg.sv */
`default_nettype none
package urx_pkg;
  // Receiver sequencer states
  typedef enum logic [1:0] {
    URX_IDLE,
    URX_START,
    URX_DATA,
    URX_STOP
  } urx_state_e;
endpackage : urx_pkg
`default_nettype wire

/* hdl/urx_receiver.sv */
`timescale 1ns/1ps
`include "urx_consts.svh"
`default_nettype none

// ----------------------------------------------------------------
// Receive buffer
// ----------------------------------------------------------------
module urx_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem; // Storage words
    logic [AW-1:0] rd;                // Read pointer
    logic [AW-1:0] wr;                // Write pointer
    logic [AW:0] cnt;                 // Words held
  } urx_fifo_s;
  urx_fifo_s s_q, s_d;
  logic push;
  logic pop;
  assign in_ready_o = (s_q.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (s_q.cnt != '0);
  assign out_data_o = s_q.mem[s_q.rd];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_ready_i & (s_q.cnt != '0);

  // Pointer wrap for non power-of-two depths
  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction : nxt

  // Next state: flush drops everything, else push and pop together
  always_comb begin
    s_d = s_q;
    if (flush_i) begin
      s_d.rd = '0;
      s_d.wr = '0;
      s_d.cnt = '0;
    end else begin
      if (push) begin
        s_d.mem[s_q.wr] = in_data_i;
        s_d.wr = nxt(s_q.wr);
      end
      if (pop) begin
        s_d.rd = nxt(s_q.rd);
      end
      s_d.cnt = (AW+1)'(s_q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : urx_fifo

// ----------------------------------------------------------------
// Asynchronous receiver with APB registers
// ----------------------------------------------------------------
module urx_receiver (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic rx_pin_i,
  output logic rx_irq_o
);
  typedef struct packed {
    logic rx_sync1;              // First synchroniser stage
    logic rx_sync2;              // Second synchroniser stage
    logic line_prev;             // Previous polarity-corrected line
    logic serial_port_enable; // Port enable, low holds reset
    logic nine_bit_receive_select; // Nine data bits per character
    logic sren;                  // Stored only, no async effect
    logic continuous_receive_enable; // Receiver on
    logic address_detect_enable; // Ninth-bit filter on
    logic overrun_error_flag; // Buffer overflowed
    logic pol;                   // Receive polarity invert
    logic wide_baud_generator_select; // Sixteen-bit divisor
    logic auto_baud_enable; // Auto-baud measurement armed
    logic abdovf;                // Auto-baud overflow
    logic high_speed_baud_select; // No divide-by-four prescale
    logic sync_sel;              // Synchronous mode select
    logic rie;                   // Receive interrupt enable
    logic [15:0] div;            // Baud divisor pair
    logic [1:0] pre;             // Low-speed prescaler
    logic [15:0] brg_cnt;        // Baud down counter
    urx_pkg::urx_state_e st;     // Receiver sequencer
    logic [3:0] phase;           // Oversample phase
    logic [3:0] bitn;            // Data bits taken
    logic [8:0] shift;           // Receive shift register
    logic [2:0] hist;            // Last three line samples
    logic abd_run;               // Auto-baud measuring low time
    logic [19:0] abd_cnt;        // Auto-baud cycle count
    logic pready;                // APB ready
    logic pslverr;               // APB error
    logic [31:0] prdata;         // APB read data
    logic irq;                   // Interrupt output
  } urx_top_s;

  urx_top_s s_q, s_d;
  logic line;                    // Polarity-corrected line
  logic tick;                    // Oversample tick
  logic mid;                     // Centre of a bit
  logic vote;                    // Majority of three samples
  logic commit;                  // APB transfer completes this edge
  logic push;
  logic [9:0] push_data;
  logic fifo_ready;
  logic fifo_valid;
  logic [9:0] fifo_data;
  logic pop;
  logic flag;                    // Unread character present
  logic [15:0] div_eff;
  logic [7:0] rsc_rd;

  // Majority of three samples
  function automatic logic maj3(input logic [2:0] h);
    return (h[0] & h[1]) | (h[1] & h[2]) | (h[0] & h[2]);
  endfunction : maj3

  // ----------------------------------------------------------------
  // Receive buffer instance
  // ----------------------------------------------------------------
  // Full buffer is the back-pressure: a full push becomes an overrun
  urx_fifo #(
    .WIDTH(`URX_FIFO_WIDTH),
    .DEPTH(`URX_FIFO_DEPTH)
  ) u_fifo (
    .clk_i(sys_clk_i),
    .reset_i(reset_i),
    .flush_i(!s_q.serial_port_enable),
    .in_valid_i(push),
    .in_ready_o(fifo_ready),
    .in_data_i(push_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(pop),
    .out_data_o(fifo_data)
  );

  // Status view: error flags and ninth bit of the oldest character
  assign flag = s_q.serial_port_enable & fifo_valid;
  assign rsc_rd = {s_q.serial_port_enable, s_q.nine_bit_receive_select, s_q.sren,
                   s_q.continuous_receive_enable, s_q.address_detect_enable,
                   fifo_valid & fifo_data[9], s_q.overrun_error_flag,
                   fifo_valid & fifo_data[8]};
  assign line = s_q.rx_sync2 ^ s_q.pol;
  assign div_eff = s_q.wide_baud_generator_select ? s_q.div : {8'h00, s_q.div[7:0]};
  assign tick = (s_q.brg_cnt == 16'h0000) &
                (s_q.high_speed_baud_select | s_q.wide_baud_generator_select | (s_q.pre == 2'h3));
  assign mid = tick & (s_q.phase == `URX_OVS_MID);
  assign vote = maj3({s_q.hist[1:0], line});
  assign commit = psel_i & penable_i & s_q.pready;
  assign pop = commit & !pwrite_i & (paddr_i == `URX_OFS_RX_DATA) & fifo_valid;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    push = 1'b0;
    push_data = '0;
    // Two-stage synchroniser on the pin
    s_d.rx_sync1 = rx_pin_i;
    s_d.rx_sync2 = s_q.rx_sync1;
    s_d.line_prev = line;

    // Baud generator: reload on zero, prescale by four unless high speed or wide divisor
    if (s_q.brg_cnt == 16'h0000) begin
      s_d.brg_cnt = div_eff;
      s_d.pre = 2'(s_q.pre + 2'h1);
    end else begin
      s_d.brg_cnt = 16'(s_q.brg_cnt - 16'h0001);
    end
    if (tick) begin
      s_d.hist = {s_q.hist[1:0], line};
      s_d.phase = 4'(s_q.phase + 4'h1);
    end

    // Receiver sequencer
    unique case (s_q.st)
      urx_pkg::URX_IDLE: begin
        // No start search while overrun or auto-baud holds the line
        if (s_q.continuous_receive_enable & !s_q.overrun_error_flag &
            !s_q.auto_baud_enable & s_q.line_prev & !line) begin
          s_d.st = urx_pkg::URX_START;
          s_d.phase = 4'h0;
        end
      end
      urx_pkg::URX_START: begin
        if (mid) begin
          if (vote) begin
            s_d.st = urx_pkg::URX_IDLE;
          end else begin
            s_d.st = urx_pkg::URX_DATA;
            s_d.bitn = 4'h0;
            s_d.phase = 4'h0 + 4'h8;
          end
        end
      end
      urx_pkg::URX_DATA: begin
        if (mid) begin
          s_d.shift = {vote, s_q.shift[8:1]};
          s_d.bitn = 4'(s_q.bitn + 4'h1);
          if (s_q.bitn == (s_q.nine_bit_receive_select ? 4'h8 : 4'h7)) begin
            s_d.st = urx_pkg::URX_STOP;
          end
        end
      end
      urx_pkg::URX_STOP: begin
        if (mid) begin
          s_d.st = urx_pkg::URX_IDLE;
          // Align 8-bit characters: shift right once more, ninth reads zero
          push_data[9] = !vote;
          push_data[8] = s_q.nine_bit_receive_select & s_q.shift[8];
          push_data[7:0] = s_q.nine_bit_receive_select ? s_q.shift[7:0] : s_q.shift[8:1];
          if (!(s_q.address_detect_enable & s_q.nine_bit_receive_select &
                !s_q.shift[8])) begin
            if (fifo_ready) begin
              push = 1'b1;
            end else begin
              s_d.overrun_error_flag = 1'b1;
            end
          end
        end
      end
    endcase

    // Auto-baud: time the start bit of a 0x55 and load the divisor
    if (s_q.auto_baud_enable & s_q.st == urx_pkg::URX_IDLE) begin
      if (!s_q.abd_run) begin
        if (s_q.line_prev & !line) begin
          s_d.abd_run = 1'b1;
          s_d.abd_cnt = '0;
        end
      end else if (line) begin
        s_d.abd_run = 1'b0;
        s_d.auto_baud_enable = 1'b0;
        s_d.div = 16'((s_q.high_speed_baud_select | s_q.wide_baud_generator_select) ?
                      (s_q.abd_cnt >> 4) : (s_q.abd_cnt >> 6)) - 16'h0001;
      end else if (s_q.abd_cnt == `URX_ABD_MAX) begin
        s_d.abd_run = 1'b0;
        s_d.auto_baud_enable = 1'b0;
        s_d.abdovf = 1'b1;
      end else begin
        s_d.abd_cnt = 20'(s_q.abd_cnt + 20'h00001);
      end
    end

    // APB: one wait state, read data captured before the final edge
    s_d.pready = psel_i & penable_i & !s_q.pready;
    if (psel_i & penable_i & !s_q.pready) begin
      s_d.pslverr = 1'b0;
      unique case (paddr_i)
        `URX_OFS_RX_STATUS_CONTROL: s_d.prdata = {24'h000000, rsc_rd};
        `URX_OFS_RX_DATA: s_d.prdata = {24'h000000, fifo_valid ? fifo_data[7:0] : 8'h00};
        `URX_OFS_BAUD_CONTROL: s_d.prdata = {24'h000000, s_q.abdovf,
                                              s_q.st == urx_pkg::URX_IDLE, 1'b0, s_q.pol,
                                              s_q.wide_baud_generator_select, 2'h0,
                                              s_q.auto_baud_enable};
        `URX_OFS_BAUD_DIV_LOW: s_d.prdata = {24'h000000, s_q.div[7:0]};
        `URX_OFS_BAUD_DIV_HIGH: s_d.prdata = {24'h000000, s_q.div[15:8]};
        `URX_OFS_TX_STATUS_CONTROL: s_d.prdata = {27'h0000000, s_q.sync_sel, 1'b0,
                                                   s_q.high_speed_baud_select, 2'h0};
        `URX_OFS_INT_CONTROL: s_d.prdata = {30'h00000000, flag, s_q.rie};
        default: begin
          s_d.prdata = 32'h00000000;
          s_d.pslverr = 1'b1;
        end
      endcase
    end
    if (commit & pwrite_i) begin
      unique case (paddr_i)
        `URX_OFS_RX_STATUS_CONTROL: begin
          s_d.serial_port_enable = pwdata_i[`URX_RSC_PORT_ENABLE];
          s_d.nine_bit_receive_select = pwdata_i[`URX_RSC_NINE_BIT];
          s_d.sren = pwdata_i[`URX_RSC_SREN];
          s_d.continuous_receive_enable = pwdata_i[`URX_RSC_RX_ENABLE];
          s_d.address_detect_enable = pwdata_i[`URX_RSC_ADDR_DETECT];
        end
        `URX_OFS_BAUD_CONTROL: begin
          s_d.pol = pwdata_i[`URX_BC_POL];
          s_d.wide_baud_generator_select = pwdata_i[`URX_BC_WIDE_DIV];
          s_d.auto_baud_enable = pwdata_i[`URX_BC_AUTO_BAUD];
          // Overflow clears on a write of zero unless it sets right now
          s_d.abdovf = s_d.abdovf & (pwdata_i[`URX_BC_ABDOVF] | !s_q.abdovf);
        end
        `URX_OFS_BAUD_DIV_LOW: s_d.div[7:0] = pwdata_i[7:0];
        `URX_OFS_BAUD_DIV_HIGH: s_d.div[15:8] = pwdata_i[7:0];
        `URX_OFS_TX_STATUS_CONTROL: begin
          s_d.sync_sel = pwdata_i[`URX_TSC_SYNC];
          s_d.high_speed_baud_select = pwdata_i[`URX_TSC_HIGH_SPEED];
        end
        `URX_OFS_INT_CONTROL: s_d.rie = pwdata_i[`URX_IC_RIE];
        default: s_d.pslverr = s_q.pslverr;
      endcase
    end

    // Receiver disabled: abandon any character not stored this cycle, overrun clears
    if (!s_d.continuous_receive_enable | s_q.sync_sel) begin
      s_d.overrun_error_flag = 1'b0;
      s_d.st = urx_pkg::URX_IDLE;
    end
    // Port disabled holds the receiver in reset; buffer is flushed too
    if (!s_q.serial_port_enable) begin
      s_d.overrun_error_flag = 1'b0;
      s_d.st = urx_pkg::URX_IDLE;
      s_d.abd_run = 1'b0;
    end
    s_d.irq = flag & s_q.rie;
  end

  // State register
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata_o = s_q.prdata;
  assign pready_o = s_q.pready;
  assign pslverr_o = s_q.pslverr;
  assign rx_irq_o = s_q.irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  sequence start_seen_s;
    s_q.st == urx_pkg::URX_START && mid && vote;
  endsequence
  irq_follows_flag_a: assert property ($past(flag & s_q.rie) == rx_irq_o)
    else $error("interrupt does not follow flag and enable");
  addr_filter_a: assert property (push && s_q.address_detect_enable &&
                                  s_q.nine_bit_receive_select |-> push_data[8])
    else $error("address mode stored a data character");
  overrun_clear_a: assert property (!s_q.continuous_receive_enable |=>
                                    !s_q.overrun_error_flag)
    else $error("overrun survived receive disable");
  eight_bit_ninth_a: assert property (push && !s_q.nine_bit_receive_select |->
                                      !push_data[8])
    else $error("eight-bit character carries a ninth bit");
  start_abort_a: assert property (start_seen_s |=> s_q.st == urx_pkg::URX_IDLE && !push)
    else $error("false start did not abort");
  overrun_hold_a: assert property (s_q.overrun_error_flag |->
                                   !push && s_q.st == urx_pkg::URX_IDLE)
    else $error("reception continued during overrun");
  port_off_a: assert property (!s_q.serial_port_enable |=>
                               !rsc_rd[`URX_RSC_FRAMING] && !s_q.overrun_error_flag)
    else $error("port disable left error flags");
  brg_reload_a: assert property (s_q.brg_cnt == 16'h0000 |=> s_q.brg_cnt == $past(div_eff))
    else $error("baud counter did not reload");
  abd_done_a: assert property (s_q.abd_run && line && s_q.auto_baud_enable &&
                               s_q.serial_port_enable
                               |=> !s_q.auto_baud_enable && !s_q.abd_run)
    else $error("auto-baud did not finish");
  framing_error_flag_push_a: assert property (push |-> push_data[9] == !vote)
    else $error("framing bit not recorded");
endmodule : urx_receiver
`default_nettype wire

/* test/urx_tx_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Remote asynchronous transmitter driving the receive line
// ----------------------------------------------------------------
module urx_tx_model (
  input wire logic clk_i,
  output logic line_o
);
  // Line inversion in use; idle is mark after inversion
  logic inv_q;

  initial begin
    inv_q = 1'b0;
    line_o = 1'b1;
  end

  // Drives one level for a whole number of clocks, always just after an edge
  task automatic hold(input logic lvl, input int clks);
    @(posedge clk_i);
    line_o <= lvl ^ inv_q;
    repeat (clks - 1) @(posedge clk_i);
  endtask : hold

  // Switches polarity; the receiver must be off, as the idle level flips
  task automatic set_inv(input logic v);
    @(posedge clk_i);
    inv_q = v;
    line_o <= ~v;
  endtask : set_inv

  // One frame: start, data LSB first, optional ninth bit, stop, idle gap
  task automatic send(input logic [8:0] d, input int nbits, input int bclk,
                      input logic stop_ok);
    hold(1'b0, bclk);
    for (int i = 0; i < nbits; i++) begin
      hold(d[i], bclk);
    end
    // A low stop bit is only sent when a scenario asks for it
    hold(stop_ok, bclk);
    hold(1'b1, 2 * bclk);
  endtask : send

  // Start edge held low for clks clocks, then back to idle for idle clocks
  task automatic glitch(input int clks, input int idle);
    hold(1'b0, clks);
    hold(1'b1, idle);
  endtask : glitch
endmodule : urx_tx_model

`default_nettype wire

/* test/testbench.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Self-checking bench for the receiver
// ----------------------------------------------------------------
module testbench;
  logic clk = 1'b0; // 25 MHz system clock
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rx_pin;
  logic irq;
  logic [31:0] rd;
  logic er;
  logic [8:0] b [4]; // Random characters in flight
  int bitc = 64; // Clocks per bit for the current divisor
  int num_errors = 0;
  int checks_done = 0;

  urx_receiver i_urx_receiver (.sys_clk_i(clk), .reset_i(rst), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .rx_pin_i(rx_pin),
    .rx_irq_o(irq));

  urx_tx_model i_urx_tx_model (.clk_i(clk), .line_o(rx_pin));

  // Half period of 20 ns
  always #20 clk = ~clk;

  // Verdict and end of run, shared with the watchdog
  task automatic give_verdict();
    if (num_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  // Compares four-state values so an unknown never matches
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check

  // One APB transfer; an edge always separates two requests
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // Wait is bounded so a dead slave cannot hang the run
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) check("pready", 1, 0);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d}, rd, er);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0, rd, er);
    check(what, exp, rd);
  endtask : rdc

  // Status word from control bits and the per-character flags
  function automatic logic [31:0] st(input logic [7:0] c, input logic fe, input logic oe,
                                     input logic d9);
    return {24'h0, c[7:3], fe, oe, d9};
  endfunction : st

  task automatic tx(input logic [8:0] d, input int n, input logic stop_ok);
    i_urx_tx_model.send(d, n, bitc, stop_ok);
  endtask : tx

  // Watchdog: about four times the expected length of the run
  initial begin
    repeat (90000) @(posedge clk);
    num_errors++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(71921));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rdc(8'h00, 32'h0, "status after reset");
    apb(1'b0, 8'h1c, 32'h0, rd, er);
    check("unmapped error", 32'h1, {31'h0, er});
    check("unmapped data", 32'h0, rd);
    // High speed, divisor 3: four clocks a tick, 64 a bit
    wr(8'h14, 8'h04);
    wr(8'h0c, 8'h03);
    wr(8'h18, 8'h01);
    wr(8'h00, 8'h90);
    // Two characters fill the buffer, then drain in order
    for (int i = 0; i < 4; i++) begin
      b[0] = 9'($urandom);
      b[1] = 9'($urandom);
      tx(b[0], 8, 1'b1);
      tx(b[1], 8, 1'b1);
      check("irq", 32'h1, {31'h0, irq});
      rdc(8'h18, 32'h3, "flag set");
      rdc(8'h00, st(8'h90, 0, 0, 0), "status");
      rdc(8'h04, {24'h0, b[0][7:0]}, "data first");
      rdc(8'h04, {24'h0, b[1][7:0]}, "data second");
      rdc(8'h18, 32'h1, "flag clear");
      check("irq low", 32'h0, {31'h0, irq});
    end
    // Framing error follows its own character only
    b[0] = 9'($urandom);
    tx(b[0], 8, 1'b0);
    tx(b[0], 8, 1'b1);
    rdc(8'h00, st(8'h90, 1, 0, 0), "framing set");
    rdc(8'h04, {24'h0, b[0][7:0]}, "bad stop data");
    rdc(8'h00, st(8'h90, 0, 0, 0), "framing next");
    rdc(8'h04, {24'h0, b[0][7:0]}, "good data");
    tx(b[0], 8, 1'b0);
    wr(8'h00, 8'h80);
    rdc(8'h00, st(8'h80, 1, 0, 0), "framing kept");
    wr(8'h00, 8'h00);
    rdc(8'h00, 32'h0, "framing forced clear");
    // Overrun: third whole character refused, fourth ignored
    wr(8'h00, 8'h90);
    for (int i = 0; i < 4; i++) begin
      b[i] = 9'($urandom);
      tx(b[i], 8, 1'b1);
    end
    rdc(8'h00, st(8'h90, 0, 1, 0), "overrun");
    rdc(8'h04, {24'h0, b[0][7:0]}, "kept first");
    rdc(8'h04, {24'h0, b[1][7:0]}, "kept second");
    rdc(8'h18, 32'h1, "nothing after overrun");
    wr(8'h00, 8'h80);
    rdc(8'h00, st(8'h80, 0, 0, 0), "overrun cleared");
    wr(8'h00, 8'h90);
    tx(b[2], 8, 1'b1);
    rdc(8'h04, {24'h0, b[2][7:0]}, "resumed");
    // Address detection with nine-bit characters
    wr(8'h00, 8'hd8);
    b[0] = {1'b0, 8'($urandom)};
    b[1] = {1'b1, 8'($urandom)};
    tx(b[0], 9, 1'b1);
    rdc(8'h18, 32'h1, "data char ignored");
    tx(b[1], 9, 1'b1);
    rdc(8'h00, st(8'hd8, 0, 0, 1), "address ninth");
    rdc(8'h04, {24'h0, b[1][7:0]}, "address data");
    wr(8'h00, 8'hd0);
    for (int i = 0; i < 2; i++) begin
      tx(b[i], 9, 1'b1);
      rdc(8'h00, st(8'hd0, 0, 0, b[i][8]), "ninth bit");
      rdc(8'h04, {24'h0, b[i][7:0]}, "any char");
    end
    // Masked interrupt: flag rises, output stays low
    wr(8'h00, 8'h90);
    wr(8'h18, 8'h00);
    tx(b[0], 8, 1'b1);
    check("irq masked", 32'h0, {31'h0, irq});
    rdc(8'h18, 32'h2, "flag masked");
    rdc(8'h04, {24'h0, b[0][7:0]}, "masked data");
    wr(8'h18, 8'h01);
    // Short low pulse is not a start bit
    // Low well short of the start centre, so all three votes see idle
    i_urx_tx_model.glitch(16, 256);
    rdc(8'h18, 32'h1, "glitch ignored");
    // Other divisor settings, both giving 128 clocks a bit
    bitc = 128;
    for (int i = 0; i < 2; i++) begin
      wr(8'h14, 8'h00);
      wr(8'h08, i ? 8'h00 : 8'h08);
      wr(8'h0c, i ? 8'h01 : 8'h07);
      wr(8'h10, 8'h00);
      b[0] = 9'($urandom);
      tx(b[0], 8, 1'b1);
      rdc(8'h04, {24'h0, b[0][7:0]}, "slow rate data");
    end
    // Auto-baud: a 72-clock low at high speed measures a divisor of 3
    wr(8'h14, 8'h04);
    wr(8'h08, 8'h01);
    i_urx_tx_model.glitch(72, 256);
    rdc(8'h0c, 32'h3, "auto-baud divisor");
    rdc(8'h08, 32'h40, "auto-baud done");
    // Inverted line; receiver off while the idle level flips
    bitc = 64;
    wr(8'h00, 8'h80);
    i_urx_tx_model.set_inv(1'b1);
    wr(8'h14, 8'h04);
    wr(8'h0c, 8'h03);
    wr(8'h08, 8'h10);
    wr(8'h00, 8'h90);
    b[0] = 9'($urandom);
    tx(b[0], 8, 1'b1);
    rdc(8'h04, {24'h0, b[0][7:0]}, "inverted data");
    rdc(8'h00, st(8'h90, 0, 0, 0), "inverted status");
    give_verdict();
  end
endmodule : testbench

`default_nettype wire
